// File: verilog/dtp_pkg.sv
// Purpose: shared constants for the down timer, pwm and buzzer block
// Assumes: apb registers, one aligned 32-bit word per register index
// Notes:   byte address is four times the register index
package dtp_pkg;

  // register indices
  localparam int         IDX_W           = 6;
  localparam logic [5:0] IDX_PS_READBACK = 6'h0d;
  localparam logic [5:0] IDX_BUZZER      = 6'h0e;
  localparam logic [5:0] IDX_COUNT_LOW   = 6'h10;
  localparam logic [5:0] IDX_CTRL_ONE    = 6'h11;
  localparam logic [5:0] IDX_CTRL_TWO    = 6'h12;
  localparam logic [5:0] IDX_DUTY_LOW    = 6'h13;
  localparam logic [5:0] IDX_HIGH_BITS   = 6'h16;
  localparam int         ADDR_W          = 8;
  localparam int         ALIGN_W         = 2;

  // timer_control_one fields
  localparam int C1_TIMER_EN  = 0;
  localparam int C1_RELOAD_EN = 1;
  localparam int C1_ONE_SHOT  = 2;
  localparam int C1_ACT_LOW   = 6;
  localparam int C1_PWM_OE    = 7;
  // timer_control_two fields
  localparam int C2_RATE_LSB  = 0;
  localparam int C2_PS_DIS_N  = 3;
  localparam int C2_EDGE_FALL = 4;
  localparam int C2_CLK_EXT   = 5;
  // buzzer_control fields
  localparam int BZ_SEL_LSB   = 0;
  localparam int BZ_EN        = 7;
  // timer_high_bits fields
  localparam int HB_DUTY_LSB  = 0;
  localparam int HB_RELOAD_LSB = 4;

  // writable bit masks, reserved bits read zero
  localparam logic [7:0] CTRL_ONE_MASK = 8'hc7;
  localparam logic [7:0] CTRL_TWO_MASK = 8'h3f;
  localparam logic [7:0] BUZZER_MASK   = 8'h8f;
  localparam logic [7:0] HIGH_MASK     = 8'h33;

  // reset values
  localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST  = 8'h3f;
  localparam logic [7:0] BUZZER_RST    = 8'h0f;
  localparam logic [7:0] HIGH_RST      = 8'h00;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [7:0] PS_RST        = 8'hff;

  // counter
  localparam int         CNT_W     = 10;
  localparam logic [9:0] COUNT_RST = 10'h000;
  localparam logic [9:0] COUNT_MAX = 10'h3ff;
  localparam logic [9:0] COUNT_MIN = 10'h000;

  typedef enum logic {RUN_COUNTING, RUN_EXPIRED} dtp_run_type;

endpackage

// File: verilog/dtp_prescaler.sv
// Purpose: binary prescaler, 2 to 256, with readable counter
// Assumes: event_in is one cycle per selected clock event
// Notes:   counts down from all ones on each event while enabled
`timescale 1ns/1ps
module dtp_prescaler #(
  parameter int PS_W = 8
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            event_in,
  input  wire logic            enable_in,
  input  wire logic [2:0]      rate_in,
  output logic      [PS_W-1:0] count_out,
  output logic                 tick_out
);
  import dtp_pkg::*;

  if (PS_W < 8) begin : g_chk
    $error("prescaler needs at least eight stages");
  end

  logic [PS_W-1:0] count;
  logic [PS_W-1:0] next_count;
  logic [PS_W-1:0] mask;

  // low rate+1 stages take part in the tick
  for (genvar i = 0; i < PS_W; i++) begin : g_mask
    assign mask[i] = (i <= int'(rate_in));
  end

  always_comb begin
    next_count = count;
    if (event_in && enable_in) begin
      next_count = count - {{(PS_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count <= PS_W'(PS_RST);
    end else begin
      count <= next_count;
    end
  end

  assign count_out = count;
  // one tick every 2**(rate+1) events; rate changes while on may glitch
  assign tick_out  = event_in && enable_in && ((count & mask) == '0);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_prescale_hold: assert property (!enable_in |=> $stable(count))
    else $error("prescaler moved while disabled");
  a_prescale_tick: assert property (
    tick_out && rate_in == 3'h0 |-> count[0] == 1'b0)
    else $error("divide by two tick on odd count");

endmodule // dtp_prescaler

// File: verilog/dtp_buzzer.sv
// Purpose: buzzer tone select from prescaler or timer count bits
// Assumes: both count inputs are register outputs
// Notes:   output and enable are registered
`timescale 1ns/1ps
module dtp_buzzer (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       enable_in,
  input  wire logic [3:0] select_in,
  input  wire logic [7:0] ps_count_in,
  input  wire logic [7:0] timer_low_in,
  output logic            tone_out,
  output logic            tone_oe_out
);
  import dtp_pkg::*;

  logic next_tone;

  always_comb begin
    next_tone = 1'b0;
    if (enable_in) begin
      if (select_in[3]) begin
        next_tone = timer_low_in[select_in[2:0]];
      end else begin
        next_tone = ps_count_in[select_in[2:0]];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tone_out    <= 1'b0;
      tone_oe_out <= 1'b0;
    end else begin
      tone_out    <= next_tone;
      tone_oe_out <= enable_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_buzz_off: assert property (!enable_in |=> !tone_out && !tone_oe_out)
    else $error("buzzer driven while disabled");
  a_buzz_prescale: assert property (enable_in && !select_in[3]
    |=> tone_out == $past(ps_count_in[select_in[2:0]]))
    else $error("buzzer prescaler tap wrong");
  a_buzz_timer: assert property (enable_in && select_in[3]
    |=> tone_out == $past(timer_low_in[select_in[2:0]]))
    else $error("buzzer timer tap wrong");
  c_buzz_timer: cover property (enable_in && select_in == 4'hf);

endmodule // dtp_buzzer

// File: verilog/dtp_timer.sv
// Purpose: 10-bit down timer with prescaler, pwm pin and buzzer over apb
// Assumes: pins synchronous to CLK_IN, which is the instruction clock
// Notes:   zero wait state apb slave, answer in the first access cycle
`timescale 1ns/1ps
module dtp_timer (
  // clock and reset
  input  wire logic                       CLK_IN,
  input  wire logic                       RST_IN,
  // apb slave
  input  wire logic                       PSEL_IN,
  input  wire logic                       PENABLE_IN,
  input  wire logic                       PWRITE_IN,
  input  wire logic [dtp_pkg::ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]                PWDATA_IN,
  output logic      [31:0]                PRDATA_OUT,
  output logic                            PREADY_OUT,
  output logic                            PSLVERR_OUT,
  // pins
  input  wire logic                       EXT_CLK_PIN_IN,
  input  wire logic                       GPIO_OUT_IN,
  input  wire logic                       GPIO_OE_IN,
  output logic                            PWM_PIN_OUT,
  output logic                            PWM_PIN_OE_OUT,
  output logic                            BUZZER_PIN_OUT,
  output logic                            BUZZER_PIN_OE_OUT
);
  import dtp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [IDX_W-1:0] idx;
  logic             aligned;
  logic             setup;
  logic             wr_done;
  logic [7:0]       wbyte;
  logic [7:0]       rd_byte;
  logic             rd_hit;

  assign idx     = PADDR_IN[ADDR_W-1:ALIGN_W];
  assign aligned = (PADDR_IN[ALIGN_W-1:0] == '0);
  assign setup   = PSEL_IN && !PENABLE_IN;
  assign wr_done = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
                   !PSLVERR_OUT;
  assign wbyte   = PWDATA_IN[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]       ctrl_one;
  logic [7:0]       ctrl_two;
  logic [7:0]       buzzer_ctl;
  logic [7:0]       high_bits;
  logic [7:0]       reload_low;
  logic [7:0]       duty_low;
  logic [CNT_W-1:0] cnt;
  dtp_run_type      run;
  logic             ext_prev;
  logic [7:0]       ps_count;
  logic             ps_tick;

  logic [7:0]       next_ctrl_one;
  logic [7:0]       next_ctrl_two;
  logic [7:0]       next_buzzer_ctl;
  logic [7:0]       next_high_bits;
  logic [7:0]       next_reload_low;
  logic [7:0]       next_duty_low;
  logic [CNT_W-1:0] next_cnt;
  dtp_run_type      next_run;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;
  logic             next_pwm_pin;
  logic             next_pwm_oe;

  logic             clk_evt;
  logic             tick;
  logic             one_shot;
  logic             wr_count;
  logic [CNT_W-1:0] reload_val;
  logic [CNT_W-1:0] duty_val;
  logic             pwm_level;

  assign one_shot   = ctrl_one[C1_ONE_SHOT];
  assign wr_count   = wr_done && idx == IDX_COUNT_LOW;
  assign reload_val = {high_bits[HB_RELOAD_LSB+1:HB_RELOAD_LSB], reload_low};
  assign duty_val   = {high_bits[HB_DUTY_LSB+1:HB_DUTY_LSB], duty_low};

  // read mux, write-only registers read zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = aligned;
    case (idx)
      IDX_PS_READBACK: rd_byte = ps_count;
      IDX_COUNT_LOW:   rd_byte = cnt[7:0];
      IDX_CTRL_ONE:    rd_byte = ctrl_one;
      IDX_CTRL_TWO:    rd_byte = ctrl_two;
      IDX_HIGH_BITS:   rd_byte = high_bits;
      IDX_BUZZER:      rd_byte = 8'h00;
      IDX_DUTY_LOW:    rd_byte = 8'h00;
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    next_pready  = setup;
    next_pslverr = setup && !rd_hit;
    next_prdata  = PRDATA_OUT;
    if (setup) begin
      next_prdata = {24'h000000, rd_byte};
    end
  end

  always_comb begin
    next_ctrl_one   = ctrl_one;
    next_ctrl_two   = ctrl_two;
    next_buzzer_ctl = buzzer_ctl;
    next_high_bits  = high_bits;
    next_duty_low   = duty_low;
    if (wr_done) begin
      case (idx)
        IDX_CTRL_ONE:  next_ctrl_one   = wbyte & CTRL_ONE_MASK;
        IDX_CTRL_TWO:  next_ctrl_two   = wbyte & CTRL_TWO_MASK;
        IDX_BUZZER:    next_buzzer_ctl = wbyte & BUZZER_MASK;
        IDX_HIGH_BITS: next_high_bits  = wbyte & HIGH_MASK;
        IDX_DUTY_LOW:  next_duty_low   = wbyte;
        default:       next_duty_low   = duty_low;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source and prescaler

  always_comb begin
    clk_evt = 1'b1;
    if (ctrl_two[C2_CLK_EXT]) begin
      if (ctrl_two[C2_EDGE_FALL]) begin
        clk_evt = ext_prev && !EXT_CLK_PIN_IN;
      end else begin
        clk_evt = !ext_prev && EXT_CLK_PIN_IN;
      end
    end
  end

  dtp_prescaler #(.PS_W(8)) u_prescaler (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .event_in  (clk_evt),
    .enable_in (!ctrl_two[C2_PS_DIS_N]),
    .rate_in   (ctrl_two[C2_RATE_LSB+2:C2_RATE_LSB]),
    .count_out (ps_count),
    .tick_out  (ps_tick)
  );

  // prescaler in path only when enabled
  assign tick = ctrl_one[C1_TIMER_EN] && run == RUN_COUNTING &&
                (ctrl_two[C2_PS_DIS_N] ? clk_evt : ps_tick);

  ////////////////////////////////////////////////////////////////////////////
  // down counter

  always_comb begin
    next_cnt        = cnt;
    next_run        = run;
    next_reload_low = reload_low;
    if (!one_shot) begin
      next_run = RUN_COUNTING;
    end
    if (wr_count) begin
      next_reload_low = wbyte;
      next_cnt = {high_bits[HB_RELOAD_LSB+1:HB_RELOAD_LSB], wbyte};
      next_run = RUN_COUNTING;
    end else if (tick) begin
      if (cnt == COUNT_MIN) begin
        if (one_shot) begin
          next_run = RUN_EXPIRED;
        end else if (ctrl_one[C1_RELOAD_EN]) begin
          next_cnt = reload_val;
        end else begin
          next_cnt = COUNT_MAX;
        end
      end else begin
        next_cnt = cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm pin

  assign pwm_level = (cnt < duty_val) ^ ctrl_one[C1_ACT_LOW];

  always_comb begin
    next_pwm_pin = GPIO_OUT_IN;
    next_pwm_oe  = GPIO_OE_IN;
    if (ctrl_one[C1_PWM_OE]) begin
      next_pwm_pin = pwm_level;
      next_pwm_oe  = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctrl_one       <= CTRL_ONE_RST;
      ctrl_two       <= CTRL_TWO_RST;
      buzzer_ctl     <= BUZZER_RST;
      high_bits      <= HIGH_RST;
      reload_low     <= BYTE_RST;
      duty_low       <= BYTE_RST;
      cnt            <= COUNT_RST;
      run            <= RUN_COUNTING;
      ext_prev       <= 1'b0;
      PRDATA_OUT     <= 32'h00000000;
      PREADY_OUT     <= 1'b0;
      PSLVERR_OUT    <= 1'b0;
      PWM_PIN_OUT    <= 1'b0;
      PWM_PIN_OE_OUT <= 1'b0;
    end else begin
      ctrl_one       <= next_ctrl_one;
      ctrl_two       <= next_ctrl_two;
      buzzer_ctl     <= next_buzzer_ctl;
      high_bits      <= next_high_bits;
      reload_low     <= next_reload_low;
      duty_low       <= next_duty_low;
      cnt            <= next_cnt;
      run            <= next_run;
      ext_prev       <= EXT_CLK_PIN_IN;
      PRDATA_OUT     <= next_prdata;
      PREADY_OUT     <= next_pready;
      PSLVERR_OUT    <= next_pslverr;
      PWM_PIN_OUT    <= next_pwm_pin;
      PWM_PIN_OE_OUT <= next_pwm_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buzzer

  dtp_buzzer u_buzzer (
    .clk_in       (CLK_IN),
    .rst_in       (RST_IN),
    .enable_in    (buzzer_ctl[BZ_EN]),
    .select_in    (buzzer_ctl[BZ_SEL_LSB+3:BZ_SEL_LSB]),
    .ps_count_in  (ps_count),
    .timer_low_in (cnt[7:0]),
    .tone_out     (BUZZER_PIN_OUT),
    .tone_oe_out  (BUZZER_PIN_OE_OUT)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  a_readback_value: assert property (setup && aligned &&
    idx == IDX_PS_READBACK |=> PRDATA_OUT[7:0] == $past(ps_count))
    else $error("prescaler readback wrong");

  a_count_read: assert property (setup && aligned && idx == IDX_COUNT_LOW
    |=> PRDATA_OUT == {24'h000000, $past(cnt[7:0])})
    else $error("count read wrong");

  a_count_load: assert property (wr_count |=> cnt ==
    {$past(high_bits[HB_RELOAD_LSB+1:HB_RELOAD_LSB]), $past(wbyte)}
    && reload_low == $past(wbyte))
    else $error("count write did not load");

  a_halt_disabled: assert property (
    !ctrl_one[C1_TIMER_EN] && !wr_count |=> $stable(cnt))
    else $error("counter moved while disabled");

  a_wrap_max: assert property (tick && cnt == COUNT_MIN && !one_shot &&
    !ctrl_one[C1_RELOAD_EN] && !wr_count |=> cnt == COUNT_MAX)
    else $error("free run did not wrap to max");

  a_wrap_reload: assert property (tick && cnt == COUNT_MIN && !one_shot &&
    ctrl_one[C1_RELOAD_EN] && !wr_count |=> cnt == $past(reload_val))
    else $error("free run did not reload");

  a_oneshot_stop: assert property (tick && cnt == COUNT_MIN && one_shot &&
    !wr_count |=> run == RUN_EXPIRED ##1 (cnt == COUNT_MIN))
    else $error("one shot kept counting");

  a_step_down: assert property (tick && cnt != COUNT_MIN && !wr_count
    |=> cnt == $past(cnt) - 10'h001)
    else $error("tick did not decrement");

  a_direct_event: assert property (ctrl_one[C1_TIMER_EN] &&
    ctrl_two[C2_PS_DIS_N] && run == RUN_COUNTING |-> tick == clk_evt)
    else $error("direct clock event lost");

  a_ext_edge: assert property (ctrl_two[C2_CLK_EXT] &&
    ctrl_two[C2_EDGE_FALL] && clk_evt |-> $fell(EXT_CLK_PIN_IN))
    else $error("external edge polarity wrong");

  a_pwm_level: assert property (ctrl_one[C1_PWM_OE] |=> PWM_PIN_OE_OUT &&
    PWM_PIN_OUT == ($past(cnt < duty_val) ^ $past(ctrl_one[C1_ACT_LOW])))
    else $error("pwm level wrong");

  a_pin_gpio: assert property (!ctrl_one[C1_PWM_OE] |=>
    PWM_PIN_OUT == $past(GPIO_OUT_IN) && PWM_PIN_OE_OUT == $past(GPIO_OE_IN))
    else $error("gpio not passed to pin");

  a_apb_answer: assert property (setup |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("apb answer timing wrong");

  c_wrap_reload: cover property (tick && cnt == COUNT_MIN && !one_shot &&
    ctrl_one[C1_RELOAD_EN]);
  c_oneshot_done: cover property (run == RUN_EXPIRED);
  c_ext_count: cover property (ctrl_two[C2_CLK_EXT] && tick);
  c_pwm_on: cover property (ctrl_one[C1_PWM_OE] && PWM_PIN_OUT);

endmodule // dtp_timer

// File: tb/dtp_pin_model.sv
// Purpose: far side of the pins, drives the external clock pin
// Assumes: pin is sampled once per CLK_IN cycle
// Notes:   pin stands still between bursts of pulses
`timescale 1ns/1ps
module dtp_pin_model (
  // clock
  input  wire logic clk_in,
  // pin
  output logic      ext_clk_out
);
  initial ext_clk_out = 1'b0;

  // full pulses, two cycles high and three cycles low, then settle
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_in) ext_clk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      ext_clk_out <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask

  // single edge, then settle
  task automatic set_level(input logic v);
    @(posedge clk_in) ext_clk_out <= v;
    repeat (5) @(posedge clk_in);
  endtask
endmodule // dtp_pin_model

// File: tb/test_dtp_timer.sv
// Purpose: self-checking bench for the down timer block
// Assumes: apb master waits for PREADY_OUT, seed fixed
// Notes:   external pin held still makes the counter deterministic
`timescale 1ns/1ps
module test_dtp_timer;
  import dtp_pkg::*;
  logic        clk, rst, psel, pen, pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, ext, gout, goe;
  logic        pwm, pwm_oe, bz, bz_oe, al, pe, b;
  logic [9:0]  v, c, d;
  logic [1:0]  e2;
  int          err_total, checked, n;

  dtp_timer i_dtp_timer (
    .CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .EXT_CLK_PIN_IN(ext), .GPIO_OUT_IN(gout), .GPIO_OE_IN(goe),
    .PWM_PIN_OUT(pwm), .PWM_PIN_OE_OUT(pwm_oe),
    .BUZZER_PIN_OUT(bz), .BUZZER_PIN_OE_OUT(bz_oe));
  dtp_pin_model i_dtp_pin_model (.clk_in(clk), .ext_clk_out(ext));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] i,
                     input logic [7:0] dat);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, dat};
    @(posedge clk) pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] dat);
    apb(1'b1, i, dat);
  endtask

  task automatic rdx(input logic [5:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  task automatic load(input logic [9:0] x);
    wr(IDX_HIGH_BITS, {2'h0, x[9:8], 4'h0});
    wr(IDX_COUNT_LOW, x[7:0]);
  endtask

  function automatic logic [9:0] step(logic [9:0] q, logic [9:0] r,
                                      logic os, logic rl);
    if (q != 10'h000) return q - 10'h001;
    if (os) return q;
    return rl ? r : 10'h3ff;
  endfunction

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    {rst, psel, pen, pwr, paddr, pwdata, gout, goe} = '0;
    rst = 1'b1;
    err_total = 0;
    checked = 0;
    void'($urandom(21602));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values and refused accesses
    rdx(IDX_CTRL_ONE, 8'h00);
    rdx(IDX_CTRL_TWO, 8'h3f);
    wr(IDX_PS_READBACK, 8'h00);
    rdx(IDX_PS_READBACK, 8'hff);
    chk({30'h0, bz, bz_oe}, 32'h0);
    apb(1'b0, 6'h3f, 8'h00);
    chk({31'h0, err}, 32'h1);
    // internal clock runs a few ticks
    wr(IDX_CTRL_TWO, 8'h08);
    load(10'h0ff);
    wr(IDX_CTRL_ONE, 8'h01);
    wr(IDX_CTRL_ONE, 8'h00);
    apb(1'b0, IDX_COUNT_LOW, 8'h00);
    chk({31'h0, rd[7:0] inside {[8'hf8:8'hfe]}}, 32'h1);
    // edge select on the external pin
    wr(IDX_CTRL_TWO, 8'h28);
    c = 10'h050;
    load(c);
    wr(IDX_CTRL_ONE, 8'h01);
    for (int e = 0; e < 2; e++) begin
      wr(IDX_CTRL_TWO, 8'h28 | 8'(e << 4));
      i_dtp_pin_model.set_level(1'b1);
      if (e == 0) c = c - 10'h001;
      rdx(IDX_COUNT_LOW, c[7:0]);
      i_dtp_pin_model.set_level(1'b0);
      if (e == 1) c = c - 10'h001;
      rdx(IDX_COUNT_LOW, c[7:0]);
    end
    // counting modes, held then enabled
    wr(IDX_CTRL_TWO, 8'h38);
    for (int m = 0; m < 4; m++) begin
      v = {2'h0, 8'($urandom_range(2, 9))};
      c = v;
      wr(IDX_CTRL_ONE, {5'h0, 2'(m), 1'b0});
      load(v);
      i_dtp_pin_model.pulses(3);
      rdx(IDX_COUNT_LOW, c[7:0]);
      wr(IDX_CTRL_ONE, {5'h0, 2'(m), 1'b1});
      n = $urandom_range(10, 25);
      i_dtp_pin_model.pulses(n);
      repeat (n) c = step(c, v, m[1], m[0]);
      rdx(IDX_COUNT_LOW, c[7:0]);
    end
    // pwm compare, polarity and pin ownership
    for (int k = 0; k < 12; k++) begin
      c = 10'($urandom);
      d = (k == 0) ? c : 10'($urandom);
      al = 1'($urandom);
      pe = (k < 2) ? 1'b1 : 1'($urandom);
      gout <= 1'($urandom);
      goe <= 1'($urandom);
      wr(IDX_HIGH_BITS, {2'h0, c[9:8], 2'h0, d[9:8]});
      wr(IDX_COUNT_LOW, c[7:0]);
      wr(IDX_DUTY_LOW, d[7:0]);
      wr(IDX_CTRL_ONE, {pe, al, 6'h00});
      repeat (3) @(posedge clk);
      e2 = pe ? {(c < d) ^ al, 1'b1} : {gout, goe};
      chk({30'h0, pwm, pwm_oe}, {30'h0, e2});
    end
    // prescaler rates, full prescaler turns
    wr(IDX_CTRL_ONE, 8'h01);
    for (int r = 0; r < 8; r++) begin
      wr(IDX_CTRL_TWO, 8'h38 | 8'(r));
      wr(IDX_CTRL_TWO, 8'h30 | 8'(r));
      load(10'h3ff);
      i_dtp_pin_model.pulses(256);
      c = 10'h3ff - 10'(256 >> (r + 1));
      rdx(IDX_COUNT_LOW, c[7:0]);
      rdx(IDX_PS_READBACK, 8'hff);
    end
    i_dtp_pin_model.pulses(5);
    rdx(IDX_PS_READBACK, 8'hfa);
    // buzzer taps over all select codes
    wr(IDX_CTRL_ONE, 8'h00);
    c = 10'($urandom);
    load(c);
    for (int s = 0; s < 16; s++) begin
      wr(IDX_BUZZER, 8'h80 | 8'(s));
      repeat (3) @(posedge clk);
      b = (s < 8) ? (((8'hfa >> s) & 8'h01) != 8'h00) : c[s - 8];
      chk({30'h0, bz, bz_oe}, {30'h0, b, 1'b1});
    end
    wr(IDX_BUZZER, 8'h0f);
    repeat (3) @(posedge clk);
    chk({30'h0, bz, bz_oe}, 32'h0);
    end_of_test();
  end
endmodule // test_dtp_timer
